//--- prps_top.sv
// Parallel receiver timing controller and output selector
//
// Overview of operation
// - Phasing counter runs modulo the per-chip decimation.
// - Count zero pulses chip one filter sync.
// - Four chips: pulses at counts 11, 23, 35.
// - Six chips: pulses at 0,7,15,23,31,39.
// - Merged output advances every 11 to 13 cycles with four chips, 7 to 9 with six.
// - Pulses drive each chip's filter sync input.
// - Oscillator and integrator syncs shared, all slaves.
// - Valid gates clock to latch chip data.
// - Valid steers latched data onto output latch.
// - Last quadrature word held during idle cycles.
// - Bursty output may be retimed by FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "prps_params.svh"
module prps_top (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  // Configuration
  input  wire prps_pkg::prps_mode_e       mode_in,
  input  wire logic                       sync_start_in,
  // Shared sync to all chips
  output logic                            oscillator_sync_input_out,
  output logic                            integrator_sync_inputs_out,
  // Per-chip filter-stage sync
  output logic [`PRPS_NCHIP-1:0]          filter_stage_sync_input_out,
  // Chip outputs
  input  wire logic [`PRPS_NCHIP-1:0]     output_valid_pulse_in,
  input  wire prps_pkg::prps_word_t       chip_data_in [`PRPS_NCHIP],
  // Merged output bus
  output prps_pkg::prps_out_s             merged_out,
  output logic                            merged_strobe_out,
  output logic [2:0]                      merged_chip_out,
  output prps_pkg::prps_cnt_t             phase_count_out
);
  import prps_pkg::*;

  // ==========================================
  // Pin synchronisers for chip outputs
  prps_mask_t valid_s1_ff;
  prps_mask_t valid_s2_ff;
  prps_mask_t valid_s3_ff;
  prps_mask_t valid_ok_ff;
  prps_word_t data_s1_ff [`PRPS_NCHIP];
  prps_word_t data_s2_ff [`PRPS_NCHIP];
  prps_word_t data_s3_ff [`PRPS_NCHIP];
  prps_word_t data_ok_ff [`PRPS_NCHIP];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      valid_s1_ff <= '0;
      valid_s2_ff <= '0;
      valid_s3_ff <= '0;
      valid_ok_ff <= '0;
    end else begin
      valid_s1_ff <= output_valid_pulse_in;
      valid_s2_ff <= valid_s1_ff;
      valid_s3_ff <= valid_s2_ff;
      valid_ok_ff <= (valid_s2_ff & valid_s3_ff) | (valid_ok_ff & (valid_s2_ff | valid_s3_ff));
    end
  end

  always_ff @(posedge core_clk_in) begin
    for (int k = 0; k < `PRPS_NCHIP; k++) begin
      data_s1_ff[k] <= chip_data_in[k];
      data_s2_ff[k] <= data_s1_ff[k];
      data_s3_ff[k] <= data_s2_ff[k];
      // One more stage so data lines up with the filtered valid
      data_ok_ff[k] <= data_s3_ff[k];
    end
  end

  // ==========================================
  // Shared sync pulse, one cycle, to all chips as slaves
  logic start_ff;
  logic shared_sync_ff;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      start_ff       <= 1'b0;
      shared_sync_ff <= 1'b0;
    end else begin
      start_ff       <= sync_start_in;
      shared_sync_ff <= sync_start_in & ~start_ff;
    end
  end

  assign oscillator_sync_input_out  = shared_sync_ff;
  assign integrator_sync_inputs_out = shared_sync_ff;

  // ==========================================
  // Phasing controller
  prps_phase_ctrl u_phase (
    .core_clk_in           (core_clk_in),
    .reset_in              (reset_in),
    .mode_in               (mode_in),
    .filter_stage_sync_out (filter_stage_sync_input_out),
    .phase_count_out       (phase_count_out)
  );

  // ==========================================
  // Chip select helper
  function automatic logic [2:0] prps_first_chip(input prps_mask_t m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int k = `PRPS_NCHIP - 1; k >= 0; k--) begin
      if (m[k]) begin
        idx = k[2:0];
      end
    end
    return idx;
  endfunction

  // ==========================================
  // Per-chip input latches, enabled by that chip's valid
  prps_word_t in_latch_ff [`PRPS_NCHIP];
  prps_mask_t lat_ff;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lat_ff <= '0;
      for (int k = 0; k < `PRPS_NCHIP; k++) begin
        in_latch_ff[k] <= `PRPS_WORD_RST;
      end
    end else begin
      lat_ff <= valid_ok_ff;
      for (int k = 0; k < `PRPS_NCHIP; k++) begin
        if (valid_ok_ff[k]) begin
          in_latch_ff[k] <= data_ok_ff[k];
        end
      end
    end
  end

  // ==========================================
  // Output selector: I then Q from the active chip
  prps_sel_st_e st_ff;
  prps_sel_st_e nxt_st;
  prps_out_s    out_ff;
  logic         strobe_ff;
  logic [2:0]   chip_ff;
  logic         any_lat;
  logic [2:0]   sel;

  assign any_lat = |lat_ff;
  assign sel     = prps_first_chip(lat_ff);

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PRPS_ST_IDLE: begin
        if (any_lat) begin
          nxt_st = PRPS_ST_I;
        end
      end
      PRPS_ST_I: begin
        nxt_st = any_lat ? PRPS_ST_Q : PRPS_ST_IDLE;
      end
      PRPS_ST_Q: begin
        nxt_st = any_lat ? PRPS_ST_I : PRPS_ST_IDLE;
      end
      default: begin
        nxt_st = PRPS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_ff <= PRPS_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Output latch clocked by the OR of all valids
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      out_ff    <= '0;
      strobe_ff <= 1'b0;
      chip_ff   <= 3'h0;
    end else if (any_lat) begin
      out_ff.word  <= in_latch_ff[sel];
      out_ff.valid <= 1'b1;
      out_ff.is_q  <= (st_ff == PRPS_ST_I);
      strobe_ff    <= 1'b1;
      chip_ff      <= sel;
    end else begin
      strobe_ff <= 1'b0;
    end
  end

  assign merged_out        = out_ff;
  // Strobe marks each burst word for any downstream retiming
  assign merged_strobe_out = strobe_ff;
  assign merged_chip_out   = chip_ff;
endmodule
`default_nettype wire

//--- prps_params.svh
// Constants for the parallel receiver phasing selector
`ifndef PRPS_PARAMS_SVH
`define PRPS_PARAMS_SVH
// ==========================================
// Phasing
`define PRPS_DECIM        8'h30
`define PRPS_CNT_W        8
`define PRPS_CNT_RST      8'h00
`define PRPS_CNT_ONE      8'h01
`define PRPS_NCHIP        6
`define PRPS_PH0          8'h00
`define PRPS_PH4_1        8'h0B
`define PRPS_PH4_2        8'h17
`define PRPS_PH4_3        8'h23
`define PRPS_PH6_1        8'h07
`define PRPS_PH6_2        8'h0F
`define PRPS_PH6_3        8'h17
`define PRPS_PH6_4        8'h1F
`define PRPS_PH6_5        8'h27
// ==========================================
// Data
`define PRPS_DW           16
`define PRPS_WORD_RST     16'h0000
`endif

//--- prps_pkg.sv
// Types for the parallel receiver phasing selector
`include "prps_params.svh"
package prps_pkg;
  typedef logic [`PRPS_CNT_W-1:0] prps_cnt_t;
  typedef logic [`PRPS_DW-1:0]    prps_word_t;
  typedef logic [`PRPS_NCHIP-1:0] prps_mask_t;
  typedef enum logic {
    PRPS_MODE_FOUR = 1'b0,
    PRPS_MODE_SIX  = 1'b1
  } prps_mode_e;
  typedef enum logic [1:0] {
    PRPS_ST_IDLE = 2'b00,
    PRPS_ST_I    = 2'b01,
    PRPS_ST_Q    = 2'b10
  } prps_sel_st_e;
  typedef struct packed {
    logic       valid;
    logic       is_q;
    prps_word_t word;
  } prps_out_s;
endpackage

//--- prps_phase_ctrl.sv
// Phasing counter and staggered filter-stage sync pulses
`timescale 1ns/100ps
`default_nettype none
`include "prps_params.svh"
module prps_phase_ctrl (
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               reset_in,
  // Configuration
  input  wire prps_pkg::prps_mode_e mode_in,
  // Sync pulses
  output logic [`PRPS_NCHIP-1:0]  filter_stage_sync_out,
  output prps_pkg::prps_cnt_t     phase_count_out
);
  import prps_pkg::*;

  prps_cnt_t  count_ff;
  prps_mask_t sync_ff;
  prps_mask_t nxt_sync;

  // ==========================================
  // Modulo counter
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      count_ff <= `PRPS_CNT_RST;
    end else if (count_ff == `PRPS_DECIM - `PRPS_CNT_ONE) begin
      count_ff <= `PRPS_CNT_RST;
    end else begin
      count_ff <= count_ff + `PRPS_CNT_ONE;
    end
  end

  // ==========================================
  // Staggered decode
  always_comb begin
    nxt_sync    = '0;
    nxt_sync[0] = (count_ff == `PRPS_PH0);
    if (mode_in == PRPS_MODE_FOUR) begin
      nxt_sync[1] = (count_ff == `PRPS_PH4_1);
      nxt_sync[2] = (count_ff == `PRPS_PH4_2);
      nxt_sync[3] = (count_ff == `PRPS_PH4_3);
    end else begin
      nxt_sync[1] = (count_ff == `PRPS_PH6_1);
      nxt_sync[2] = (count_ff == `PRPS_PH6_2);
      nxt_sync[3] = (count_ff == `PRPS_PH6_3);
      nxt_sync[4] = (count_ff == `PRPS_PH6_4);
      nxt_sync[5] = (count_ff == `PRPS_PH6_5);
    end
  end

  // Registered one-cycle pulses to each chip
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign filter_stage_sync_out = sync_ff;
  assign phase_count_out       = count_ff;
endmodule
`default_nettype wire

//--- prps_props.sv
// Checker for the phasing selector
`timescale 1ns/100ps
`default_nettype none
module prps_props (
  // Clock, reset, control
  input wire logic                 core_clk_in,
  input wire logic                 reset_in,
  input wire prps_pkg::prps_mode_e mode_in,
  input wire logic                 sync_start_in,
  // Observed ports
  input wire logic                 oscillator_sync_input_out,
  input wire logic                 integrator_sync_inputs_out,
  input wire logic [5:0]           filter_stage_sync_input_out,
  input wire logic [5:0]           output_valid_pulse_in,
  input wire prps_pkg::prps_out_s  merged_out,
  input wire logic                 merged_strobe_out,
  input wire prps_pkg::prps_cnt_t  phase_count_out
);
  import prps_pkg::*;
  logic [5:0] s;
  logic [7:0] c;
  assign s = filter_stage_sync_input_out;
  assign c = phase_count_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // Assertions
  count_wrap_a: assert property (c == 8'h2F |=> c == 8'h00) else $error("count wrap");
  count_step_a: assert property (!$past(reset_in) && c < 8'h2F |=> c == $past(c) + 8'h01)
    else $error("count step");
  first_sync_a: assert property (!$past(reset_in) |-> s[0] == ($past(c) == 8'h00))
    else $error("chip one sync");
  four_sync_a: assert property (!$past(reset_in) && mode_in == PRPS_MODE_FOUR |->
    s[5:1] == {2'b00, $past(c) == 8'h23, $past(c) == 8'h17, $past(c) == 8'h0B}) else $error("four sync");
  six_sync_a: assert property (!$past(reset_in) && mode_in == PRPS_MODE_SIX |-> s[5:1] ==
    {$past(c) == 8'h27, $past(c) == 8'h1F, $past(c) == 8'h17, $past(c) == 8'h0F, $past(c) == 8'h07})
    else $error("six sync");
  shared_sync_a: assert property ($rose(sync_start_in) |-> ##[1:2] oscillator_sync_input_out
    && integrator_sync_inputs_out) else $error("shared sync");
  merge_lat_a: assert property ($rose(|output_valid_pulse_in) |-> ##6 merged_strobe_out)
    else $error("merge latency");
  idle_hold_a: assert property (!merged_strobe_out |-> $stable(merged_out)) else $error("idle hold");
  iq_order_a: assert property (merged_strobe_out && merged_out.is_q |->
    $past(merged_strobe_out) && !$past(merged_out.is_q)) else $error("iq order");
  four_c: cover property (mode_in == PRPS_MODE_FOUR && s[3]);
  six_c: cover property (s[5]);
  q_c: cover property (merged_strobe_out && merged_out.is_q);
endmodule
bind prps_top prps_props u_props (.core_clk_in, .reset_in, .mode_in, .sync_start_in,
  .oscillator_sync_input_out, .integrator_sync_inputs_out, .filter_stage_sync_input_out,
  .output_valid_pulse_in, .merged_out, .merged_strobe_out, .phase_count_out);
`default_nettype wire

//--- prps_chip_model.sv
// Model of the parallel receiver chips
`timescale 1ns/100ps
`default_nettype none
module prps_chip_model #(parameter int LAT = 5) (
  // Clock and board reset
  input  wire logic            core_clk_in,
  input  wire logic            reset_in,
  // Filter sync and chip outputs
  input  wire logic [5:0]      sync_in,
  output logic [5:0]           valid_out,
  output prps_pkg::prps_word_t data_out [6]
);
  import prps_pkg::*;
  int         cnt_ff [6];
  logic [7:0] tick_ff;
  always_ff @(posedge core_clk_in) begin
    tick_ff <= reset_in ? 8'h00 : tick_ff + 8'h01;
    for (int i = 0; i < 6; i++) begin
      if (reset_in) cnt_ff[i] <= 0;
      else if (sync_in[i]) cnt_ff[i] <= 1;
      else if (cnt_ff[i] != 0) cnt_ff[i] <= (cnt_ff[i] == LAT + 2) ? 0 : cnt_ff[i] + 1;
    end
  end
  // Idle pins show a moving pattern
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      valid_out[i] = cnt_ff[i] > LAT;
      data_out[i] = valid_out[i] ? {4'(i), 11'h5A5, cnt_ff[i] == LAT + 2} : {2{tick_ff}};
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the phasing selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import prps_pkg::*;
  logic       core_clk_in, reset_in, sync_start_in, strobe, osc, integ;
  prps_mode_e mode_in;
  logic [5:0] fsync, valid;
  prps_word_t data [6];
  prps_out_s  merged;
  logic [2:0] chip;
  prps_cnt_t  count;
  int         mismatches, checks, cyc, prev, n, ni;
  int         last_cyc [8];
  logic [11:0] rows [10] = '{12'h000, 12'h10B, 12'h217, 12'h323, 12'h800,
                             12'h907, 12'hA0F, 12'hB17, 12'hC1F, 12'hD27};
  prps_top dut (.core_clk_in, .reset_in, .mode_in, .sync_start_in, .oscillator_sync_input_out(osc),
    .integrator_sync_inputs_out(integ), .filter_stage_sync_input_out(fsync), .output_valid_pulse_in(valid),
    .chip_data_in(data), .merged_out(merged), .merged_strobe_out(strobe), .merged_chip_out(chip),
    .phase_count_out(count));
  prps_chip_model model (.core_clk_in, .reset_in, .sync_in(fsync), .valid_out(valid), .data_out(data));
  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [15:0] exp, got);
    checks++;
    if (exp !== got) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset(input prps_mode_e m);
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    mode_in <= m;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
  endtask
  task automatic wait_bit(input int b);
    int k;
    k = 0;
    while (fsync[b] !== 1'b1) begin
      @(posedge core_clk_in);
      #1;
      k++;
      if (k > 100) begin
        check("sync wait", 16'h0001, 16'h0000);
        finish_test();
      end
    end
  endtask
  // ==========================================
  // Merged output monitor
  always @(negedge core_clk_in) begin
    cyc++;
    if (reset_in) begin
      last_cyc = '{default: 0};
      prev = -1;
    end else if (strobe === 1'b1) begin
      if (merged.is_q === 1'b0) begin
        if (prev >= 0) check("chip order", 16'((prev + 1) % (mode_in == PRPS_MODE_FOUR ? 4 : 6)), 16'(chip));
        if (last_cyc[chip] > 0) check("chip period", 16'h0030, 16'(cyc - last_cyc[chip]));
        prev = int'(chip);
        last_cyc[chip] = cyc;
      end
      check("word source", 16'(chip), 16'(merged.word[15:12]));
      check("word valid", 16'h0001, 16'(merged.valid));
      check("word half", 16'(merged.is_q), 16'(merged.word[0]));
    end
  end
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  initial begin
    reset_in = 1'b1;
    mode_in = PRPS_MODE_FOUR;
    sync_start_in = 1'b0;
    @(posedge core_clk_in);
    for (int r = 0; r < 10; r++) begin
      if (r == 0 || rows[r][11] != rows[r-1][11]) do_reset(prps_mode_e'(rows[r][11]));
      wait_bit(rows[r][10:8]);
      check("sync count", 16'(rows[r][7:0] + 8'h01), 16'(count));
    end
    @(posedge core_clk_in) sync_start_in <= 1'b1;
    repeat (5) begin
      @(posedge core_clk_in);
      #1 n += osc;
      ni += integ;
    end
    check("shared pulses", 16'h0001, 16'(n));
    check("integrator pulses", 16'h0001, 16'(ni));
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b1;
    @(posedge core_clk_in);
    #1 check("reset count", 16'h0000, 16'(count));
    @(posedge core_clk_in) reset_in <= 1'b0;
    wait_bit(0);
    check("first pulse", 16'h0001, 16'(count));
    repeat (150) @(posedge core_clk_in);
    finish_test();
  end
endmodule
`default_nettype wire
